// [core/sdc_pkg.sv]
// Constants, state types and register map of the screwdriver motor and charge controller
//======================================================================
// Behaviour
// - Drive the motor in unscrew direction while the unscrew button is held, screw direction while screw is held.
// - Outside tightening, power the motor drive down when no button or both buttons are pressed.
// - After screw drive stops, give five tightening pulses at 10 Hz within 500 ms, then power down.
// - Generate the motor PWM at about 50 kHz.
// - Adjust the motor duty from the load voltage comparator to hold the average bridge voltage.
// - Suppress the motor PWM while the motor current comparator is high.
// - Ignore the motor current comparator for a 3 us blanking delay at the start of each chopper cycle.
// - Allow motor operation only while the supply is above 3 V.
// - Light the motor-on lamp exactly while the motor is driven.
// - Hold the charge lamp on while charging and blink it once charging is done.
// - Start charge sequencing only with USB present, then pick the phase from the battery comparators.
// - Below 3 V precharge with the reference up/down control low, using the 160 mV entry.
// - When the low battery comparator goes high enter constant current with up/down high, using 1160 mV.
// - The reference file holds 29 in byte 0 and 4 in bytes 1 to 7, and software may change them.
// - Stay in constant current until the full voltage comparator shows 4.2 V, then go constant voltage.
// - When fully charged stop charging and raise the charge done sleep signal.
package sdc_pkg;
    //======================================================================
    // Timing
    localparam int CLK_HZ          = 25_000_000;
    localparam int CLK_PERIOD_NS   = 40;
    localparam int MOTOR_PWM_HZ    = 50_000;
    localparam int MOTOR_PWM_CYC   = CLK_HZ / MOTOR_PWM_HZ;
    localparam int BLANK_NS        = 3000;
    localparam int BLANK_CYC       = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIGHTEN_HZ      = 10;
    localparam int TIGHTEN_PULSES  = 5;
    localparam int TIGHTEN_WIN_MS  = 500;
    localparam int TIGHTEN_CYC     = CLK_HZ / TIGHTEN_HZ;
    localparam int BLINK_HZ        = 2;
    localparam int BLINK_CYC       = CLK_HZ / BLINK_HZ;
    localparam int SLOW_W          = 24;

    //======================================================================
    // Motor duty loop
    localparam int         DUTY_W     = 9;
    localparam logic [8:0] DUTY_RESET = 9'h0fa;
    localparam logic [8:0] DUTY_MIN   = 9'h001;
    localparam logic [8:0] DUTY_MAX   = 9'(MOTOR_PWM_CYC - 1);
    localparam logic [8:0] BLANK_END  = 9'(BLANK_CYC);

    //======================================================================
    // Charge reference file
    localparam int         REF_BYTES     = 8;
    localparam logic [7:0] REF_CC_RESET  = 8'h1d;
    localparam logic [7:0] REF_PRE_RESET = 8'h04;

    //======================================================================
    // Register map, byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_REF_LO = 8'h08;
    localparam logic [7:0] ADDR_REF_HI = 8'h0c;
    localparam int         CTRL_MOTOR_EN  = 0;
    localparam int         CTRL_CHARGE_EN = 1;
    localparam logic [1:0] CTRL_RESET     = 2'h3;

    //======================================================================
    // States, Gray coded along the usual path
    typedef enum logic [2:0] {
        M_IDLE    = 3'b000,
        M_SCREW   = 3'b001,
        M_TIGHTEN = 3'b011,
        M_OFF     = 3'b010,
        M_UNSCREW = 3'b100
    } sdc_motor_st_t;

    typedef enum logic [2:0] {
        C_IDLE = 3'b000,
        C_PRE  = 3'b001,
        C_CC   = 3'b011,
        C_CV   = 3'b010,
        C_DONE = 3'b110
    } sdc_chg_st_t;
endpackage

// [core/sdc_ctrl.sv]
// Screwdriver motor drive and battery charge sequencer with APB registers
`timescale 1ns/100ps
`default_nettype none
module sdc_ctrl
    import sdc_pkg::*;
#(
    parameter int TIGHTEN_PERIOD_CYC = TIGHTEN_CYC,
    parameter int BLINK_PERIOD_CYC   = BLINK_CYC
) (
    // Clock, reset, enable
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_CLK_EN,
    // APB slave
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // Buttons and motor comparators
    input  wire logic        I_UNSCREW_BUTTON,
    input  wire logic        I_SCREW_BUTTON,
    input  wire logic        I_MOTOR_CURRENT_COMPARATOR,
    input  wire logic        I_LOAD_VOLTAGE_HIGH,
    // Battery and charge comparators
    input  wire logic        I_USB_PRESENT,
    input  wire logic        I_LOW_BATTERY_COMPARATOR,
    input  wire logic        I_FULL_VOLTAGE_COMPARATOR,
    input  wire logic        I_CHARGE_CURRENT_COMPARATOR,
    // Motor bridge and lamps
    output logic             O_MOTOR_PWM_SCREW,
    output logic             O_MOTOR_PWM_UNSCREW,
    output logic             O_POWER_DOWN,
    output logic             O_MOTOR_ON_LAMP,
    output logic             O_CHARGE_LAMP,
    // Charge path
    output logic             O_CHARGE_REF_UP,
    output logic             O_CHARGE_REFERENCE_PWM,
    output logic             O_CHARGE_DONE_SLEEP
);

    //======================================================================
    // Register file
    logic [1:0]  ctrl;
    logic [1:0]  next_ctrl;
    logic [7:0]  ref_byte      [REF_BYTES];
    logic [7:0]  next_ref_byte [REF_BYTES];
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        acc;
    logic        hit;

    sdc_motor_st_t m_st;
    sdc_motor_st_t next_m_st;
    sdc_chg_st_t   c_st;
    sdc_chg_st_t   next_c_st;
    logic [DUTY_W-1:0] duty;

    // Two cycle access keeps read data coming straight from a flop
    always_comb begin
        acc          = I_PSEL & I_PENABLE & ~O_PREADY;
        hit          = (I_PADDR == ADDR_CTRL) | (I_PADDR == ADDR_STATUS)
                     | (I_PADDR == ADDR_REF_LO) | (I_PADDR == ADDR_REF_HI);
        next_ctrl    = ctrl;
        next_ref_byte = ref_byte;
        next_pready  = acc;
        next_pslverr = acc & ~hit;
        next_prdata  = 32'h0;
        if (acc & I_PWRITE) begin
            case (I_PADDR)
                ADDR_CTRL: next_ctrl = I_PWDATA[1:0];
                ADDR_REF_LO: begin
                    for (int i = 0; i < 4; i++) begin
                        next_ref_byte[i] = I_PWDATA[8*i +: 8];
                    end
                end
                ADDR_REF_HI: begin
                    for (int i = 0; i < 4; i++) begin
                        next_ref_byte[i+4] = I_PWDATA[8*i +: 8];
                    end
                end
                default: next_ctrl = ctrl;
            endcase
        end
        if (acc & ~I_PWRITE) begin
            case (I_PADDR)
                ADDR_CTRL:   next_prdata = {30'h0, ctrl};
                ADDR_STATUS: next_prdata = {7'h0, duty, 9'h0, c_st, 1'b0, m_st};
                ADDR_REF_LO: next_prdata = {ref_byte[3], ref_byte[2], ref_byte[1], ref_byte[0]};
                ADDR_REF_HI: next_prdata = {ref_byte[7], ref_byte[6], ref_byte[5], ref_byte[4]};
                default:     next_prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            ctrl      <= CTRL_RESET;
            O_PREADY  <= 1'b0;
            O_PSLVERR <= 1'b0;
            O_PRDATA  <= 32'h0;
            ref_byte[0] <= REF_CC_RESET;
            for (int i = 1; i < REF_BYTES; i++) begin
                ref_byte[i] <= REF_PRE_RESET;
            end
        end else if (I_CLK_EN) begin
            ctrl      <= next_ctrl;
            O_PREADY  <= next_pready;
            O_PSLVERR <= next_pslverr;
            O_PRDATA  <= next_prdata;
            ref_byte  <= next_ref_byte;
        end
    end

    //======================================================================
    // Motor PWM with duty loop and chopper
    logic [DUTY_W-1:0] pwm_cnt;
    logic [DUTY_W-1:0] next_pwm_cnt;
    logic [DUTY_W-1:0] next_duty;
    logic              pwm_wrap;
    logic              pwm_gated;

    always_comb begin
        pwm_wrap     = (pwm_cnt == DUTY_MAX);
        next_pwm_cnt = pwm_wrap ? '0 : pwm_cnt + 9'h001;
        next_duty    = duty;
        if (pwm_wrap) begin
            // One step per period keeps the loop slower than the integrator
            if (I_LOAD_VOLTAGE_HIGH && duty > DUTY_MIN) begin
                next_duty = duty - 9'h001;
            end else if (!I_LOAD_VOLTAGE_HIGH && duty < DUTY_MAX) begin
                next_duty = duty + 9'h001;
            end
        end
        // Current is checked only after the switching spike has settled
        pwm_gated = (pwm_cnt < duty)
                  & ~(I_MOTOR_CURRENT_COMPARATOR & (pwm_cnt >= BLANK_END));
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            pwm_cnt <= '0;
            duty    <= DUTY_RESET;
        end else if (I_CLK_EN) begin
            pwm_cnt <= next_pwm_cnt;
            duty    <= next_duty;
        end
    end

    //======================================================================
    // Direction, hold-to-run and tightening
    logic [SLOW_W-1:0] tick;
    logic [SLOW_W-1:0] next_tick;
    logic [2:0]        pulses;
    logic [2:0]        next_pulses;
    logic              bat_ok;
    logic              only_u;
    logic              only_s;
    logic              tick_end;
    logic              tight_on;
    logic              drv_s;
    logic              drv_u;

    always_comb begin
        bat_ok      = I_LOW_BATTERY_COMPARATOR & ctrl[CTRL_MOTOR_EN];
        only_u      = I_UNSCREW_BUTTON & ~I_SCREW_BUTTON;
        only_s      = I_SCREW_BUTTON & ~I_UNSCREW_BUTTON;
        tick_end    = (tick == SLOW_W'(TIGHTEN_PERIOD_CYC - 1));
        tight_on    = (m_st == M_TIGHTEN) && (tick < SLOW_W'(TIGHTEN_PERIOD_CYC / 2));
        next_m_st   = m_st;
        next_tick   = '0;
        next_pulses = '0;
        case (m_st)
            M_IDLE: begin
                if (bat_ok && only_u) begin
                    next_m_st = M_UNSCREW;
                end else if (bat_ok && only_s) begin
                    next_m_st = M_SCREW;
                end
            end
            M_UNSCREW: begin
                if (!bat_ok || !only_u) begin
                    next_m_st = M_IDLE;
                end
            end
            M_SCREW: begin
                if (!bat_ok || I_UNSCREW_BUTTON) begin
                    next_m_st = M_IDLE;
                end else if (!I_SCREW_BUTTON) begin
                    next_m_st = M_TIGHTEN;
                end
            end
            M_TIGHTEN: begin
                next_tick   = tick_end ? '0 : tick + 1'b1;
                next_pulses = tick_end ? pulses + 3'h1 : pulses;
                if (!bat_ok) begin
                    next_m_st = M_IDLE;
                end else if (tick_end && pulses == 3'(TIGHTEN_PULSES - 1)) begin
                    next_m_st = M_OFF;
                end
            end
            M_OFF: begin
                // Stays powered down until a button wakes it
                if (I_UNSCREW_BUTTON || I_SCREW_BUTTON) begin
                    next_m_st = M_IDLE;
                end
            end
            default: next_m_st = M_IDLE;
        endcase
        drv_s = (m_st == M_SCREW) | tight_on;
        drv_u = (m_st == M_UNSCREW);
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            m_st                <= M_IDLE;
            tick                <= '0;
            pulses              <= '0;
            O_MOTOR_PWM_SCREW   <= 1'b0;
            O_MOTOR_PWM_UNSCREW <= 1'b0;
            O_MOTOR_ON_LAMP     <= 1'b0;
            O_POWER_DOWN        <= 1'b1;
        end else if (I_CLK_EN) begin
            m_st                <= next_m_st;
            tick                <= next_tick;
            pulses              <= next_pulses;
            O_MOTOR_PWM_SCREW   <= drv_s & pwm_gated;
            O_MOTOR_PWM_UNSCREW <= drv_u & pwm_gated;
            O_MOTOR_ON_LAMP     <= drv_s | drv_u;
            O_POWER_DOWN        <= ~(drv_s | drv_u);
        end
    end

    //======================================================================
    // Charge sequencer and reference PWM
    logic [7:0]        ref_cnt;
    logic [SLOW_W-1:0] blink;
    logic [SLOW_W-1:0] next_blink;
    logic              chg_en;
    logic              ref_up;
    logic              charging;
    logic [7:0]        ref_val;

    always_comb begin
        chg_en    = I_USB_PRESENT & ctrl[CTRL_CHARGE_EN];
        next_c_st = c_st;
        case (c_st)
            C_IDLE: begin
                if (chg_en) begin
                    next_c_st = I_LOW_BATTERY_COMPARATOR ? C_CC : C_PRE;
                end
            end
            C_PRE: begin
                if (I_LOW_BATTERY_COMPARATOR) begin
                    next_c_st = C_CC;
                end
            end
            C_CC: begin
                if (I_FULL_VOLTAGE_COMPARATOR) begin
                    next_c_st = C_CV;
                end
            end
            C_CV: begin
                // Current has tapered below the low reference
                if (!I_CHARGE_CURRENT_COMPARATOR) begin
                    next_c_st = C_DONE;
                end
            end
            C_DONE:  next_c_st = C_DONE;
            default: next_c_st = C_IDLE;
        endcase
        if (!chg_en) begin
            next_c_st = C_IDLE;
        end
        ref_up     = (c_st == C_CC);
        ref_val    = ref_up ? ref_byte[0] : ref_byte[1];
        charging   = (c_st == C_PRE) | (c_st == C_CC) | (c_st == C_CV);
        next_blink = (c_st != C_DONE || blink == SLOW_W'(BLINK_PERIOD_CYC - 1)) ? '0 : blink + 1'b1;
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            c_st                   <= C_IDLE;
            ref_cnt                <= '0;
            blink                  <= '0;
            O_CHARGE_REF_UP        <= 1'b0;
            O_CHARGE_REFERENCE_PWM <= 1'b0;
            O_CHARGE_LAMP          <= 1'b0;
            O_CHARGE_DONE_SLEEP    <= 1'b0;
        end else if (I_CLK_EN) begin
            c_st                   <= next_c_st;
            ref_cnt                <= ref_cnt + 8'h01;
            blink                  <= next_blink;
            O_CHARGE_REF_UP        <= ref_up;
            O_CHARGE_REFERENCE_PWM <= charging & (ref_cnt < ref_val);
            O_CHARGE_LAMP          <= charging
                                    | ((c_st == C_DONE) && blink < SLOW_W'(BLINK_PERIOD_CYC / 2));
            O_CHARGE_DONE_SLEEP    <= (c_st == C_DONE);
        end
    end

endmodule
`default_nettype wire

// [verification/sdc_chk.sv]
// Concurrent checks on the screwdriver controller ports
`timescale 1ns/100ps
`default_nettype none
module sdc_chk (
    // Clock and reset
    input wire logic        I_REF_CLK,
    input wire logic        I_RST,
    // Inputs watched
    input wire logic        I_UNSCREW_BUTTON,
    input wire logic        I_MOTOR_CURRENT_COMPARATOR,
    input wire logic        I_LOW_BATTERY_COMPARATOR,
    input wire logic        I_USB_PRESENT,
    // Outputs watched
    input wire logic [31:0] O_PRDATA,
    input wire logic        O_PREADY,
    input wire logic        O_PSLVERR,
    input wire logic        O_MOTOR_PWM_SCREW,
    input wire logic        O_MOTOR_PWM_UNSCREW,
    input wire logic        O_POWER_DOWN,
    input wire logic        O_MOTOR_ON_LAMP,
    input wire logic        O_CHARGE_LAMP,
    input wire logic        O_CHARGE_REF_UP,
    input wire logic        O_CHARGE_DONE_SLEEP
);
    logic       drive;
    logic [9:0] run;
    logic [9:0] next_run;
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);
    //======================================================================
    // Unbroken drive length, so the chop can be judged past the blanking time
    assign drive = O_MOTOR_PWM_SCREW | O_MOTOR_PWM_UNSCREW;
    always_comb begin
        next_run = drive ? run + 10'h001 : 10'h000;
    end
    always_ff @(posedge I_REF_CLK) begin
        run <= I_RST ? 10'h000 : next_run;
    end
    //======================================================================
    // Properties
    dir_exclusive_a: assert property (!(O_MOTOR_PWM_SCREW && O_MOTOR_PWM_UNSCREW))
        else $error("both bridge directions driven");
    off_no_drive_a: assert property (O_POWER_DOWN |-> !drive)
        else $error("bridge driven while powered down");
    lamp_follows_a: assert property (O_MOTOR_ON_LAMP == !O_POWER_DOWN)
        else $error("motor lamp disagrees with drive");
    unscrew_held_a: assert property (O_MOTOR_PWM_UNSCREW |-> $past(I_UNSCREW_BUTTON) || $past(I_UNSCREW_BUTTON, 2))
        else $error("unscrew drive without button");
    batt_low_off_a: assert property ((!I_LOW_BATTERY_COMPARATOR) [*3] |-> O_POWER_DOWN)
        else $error("motor on with low battery");
    chop_after_blank_a: assert property (drive && run > 10'd76 |-> !$past(I_MOTOR_CURRENT_COMPARATOR))
        else $error("overcurrent not chopped after blanking");
    cc_lamp_on_a: assert property (O_CHARGE_REF_UP |-> O_CHARGE_LAMP && !O_CHARGE_DONE_SLEEP)
        else $error("charge lamp off in constant current");
    no_usb_idle_a: assert property ((!I_USB_PRESENT) [*3] |-> !(O_CHARGE_REF_UP || O_CHARGE_LAMP || O_CHARGE_DONE_SLEEP))
        else $error("charging without supply");
    pready_pulse_a: assert property (O_PREADY |=> !O_PREADY)
        else $error("ready held beyond one cycle");
    slverr_data_a: assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h0)
        else $error("error response malformed");
endmodule
`default_nettype wire

// [verification/sdc_motor_model.sv]
// Far-side model of the motor bridge: averaged voltage and stall current
`timescale 1ns/100ps
`default_nettype none
module sdc_motor_model
    import sdc_pkg::*;
(
    // Clock and bridge drive
    input  wire logic       i_clk,
    input  wire logic       i_pwm_screw,
    input  wire logic       i_pwm_unscrew,
    // Bench commands
    input  wire logic       i_stall,
    input  wire logic [9:0] i_target,
    // Comparators back to the controller
    output logic            o_current_high,
    output logic            o_voltage_high
);
    logic [9:0] win_cnt   = 10'h000;
    logic [9:0] high_cnt  = 10'h000;
    logic       volt_high = 1'b0;
    // A stalled rotor keeps current up in the off time too, so chopping cannot clear it
    assign o_current_high = i_stall;
    assign o_voltage_high = volt_high;
    // One full PWM period of driven cycles stands in for the integrated bridge voltage
    always @(posedge i_clk) begin
        if (win_cnt == 10'(MOTOR_PWM_CYC - 1)) begin
            win_cnt   <= 10'h000;
            high_cnt  <= 10'h000;
            volt_high <= (high_cnt > i_target);
        end else begin
            win_cnt  <= win_cnt + 10'h001;
            high_cnt <= high_cnt + 10'(i_pwm_screw | i_pwm_unscrew);
        end
    end
endmodule
`default_nettype wire

// [verification/sdc_ctrl_bench.sv]
// Self-checking bench for the screwdriver motor and charge controller
`timescale 1ns/100ps
`default_nettype none
module sdc_ctrl_bench;
    import sdc_pkg::*;
    localparam int TP = 40;
    logic clk = 1'b0, rst = 1'b1, clken = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, stall = 1'b0;
    logic unscrew = 1'b0, screw = 1'b0, usb = 1'b0, lowb = 1'b1, fullv = 1'b0, chgc = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [9:0] target = 10'd300;
    logic [31:0] pwdata = 32'h0, prdata, rd, d1;
    logic pready, pslverr, err, pws, pwu, pd, mlamp, clamp, refup, refpwm, sleep, cmp, loadh;
    int num_errors = 0, samples_checked = 0, cycles = 0, hi, ro;
    always #20 clk = ~clk;
    sdc_ctrl #(.TIGHTEN_PERIOD_CYC(TP), .BLINK_PERIOD_CYC(20)) dut (
        .I_REF_CLK(clk), .I_RST(rst), .I_CLK_EN(clken), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_UNSCREW_BUTTON(unscrew), .I_SCREW_BUTTON(screw), .I_MOTOR_CURRENT_COMPARATOR(cmp),
        .I_LOAD_VOLTAGE_HIGH(loadh), .I_USB_PRESENT(usb), .I_LOW_BATTERY_COMPARATOR(lowb),
        .I_FULL_VOLTAGE_COMPARATOR(fullv), .I_CHARGE_CURRENT_COMPARATOR(chgc), .O_MOTOR_PWM_SCREW(pws),
        .O_MOTOR_PWM_UNSCREW(pwu), .O_POWER_DOWN(pd), .O_MOTOR_ON_LAMP(mlamp), .O_CHARGE_LAMP(clamp),
        .O_CHARGE_REF_UP(refup), .O_CHARGE_REFERENCE_PWM(refpwm), .O_CHARGE_DONE_SLEEP(sleep));
    sdc_motor_model u_motor (.i_clk(clk), .i_pwm_screw(pws), .i_pwm_unscrew(pwu), .i_stall(stall),
        .i_target(target), .o_current_high(cmp), .o_voltage_high(loadh));
    //======================================================================
    // Shared tasks
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
            num_errors++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Idle edge first, so a release and the next setup never share a time step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        // Waits as long as the slave needs; only the bench timeout ends a hung access
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return pws;
            1: return pwu;
            2: return !mlamp;
            3: return clamp;
            default: return refpwm;
        endcase
    endfunction
    // High cycles and rising edges of one output over a window
    task automatic watch(input int s, input int n);
        logic last;
        last = pick(s);
        hi = 0;
        ro = 0;
        repeat (n) begin
            @(posedge clk);
            hi += int'(pick(s));
            ro += int'(pick(s) & !last);
            last = pick(s);
        end
    endtask
    //======================================================================
    // Scenarios
    task automatic t_regs();
        chk("power_down", pd, 1);
        chk("no_usb_lamp", clamp, 0);
        apb(0, ADDR_CTRL, 0);
        chk("ctrl", rd, 32'h3);
        apb(0, ADDR_REF_LO, 0);
        chk("ref_lo", rd, 32'h0404041d);
        apb(0, ADDR_REF_HI, 0);
        chk("ref_hi", rd, 32'h04040404);
        apb(0, 8'h20, 0);
        chk("slverr", err, 1);
        $display("registers done");
    endtask
    task automatic t_motor();
        unscrew <= 1'b1;
        cyc(10);
        watch(1, 5000);
        chk("unscrew_rises", ro, 10);
        chk("motor_lamp", mlamp, 1);
        watch(0, 500);
        chk("screw_high", hi, 0);
        screw <= 1'b1;
        cyc(6);
        watch(1, 500);
        chk("both_high", hi, 0);
        chk("both_off", pd, 1);
        screw <= 1'b0;
        cyc(6);
        chk("unscrew_again", pd, 0);
        unscrew <= 1'b0;
        cyc(6);
        chk("release_off", pd, 1);
        // Clock enable low must freeze the state machine against a fresh press
        clken <= 1'b0;
        unscrew <= 1'b1;
        cyc(6);
        chk("frozen_off", pd, 1);
        clken <= 1'b1;
        cyc(6);
        chk("thawed_on", pd, 0);
        unscrew <= 1'b0;
        cyc(6);
        $display("motor direction done");
    endtask
    task automatic t_chop();
        unscrew <= 1'b1;
        stall <= 1'b1;
        cyc(600);
        watch(1, 5000);
        chk("chop_high", hi, 10 * BLANK_CYC);
        stall <= 1'b0;
        target <= 10'd100;
        cyc(1000);
        apb(0, ADDR_STATUS, 0);
        d1 = rd;
        cyc(5000);
        apb(0, ADDR_STATUS, 0);
        chk("duty_down", 32'(rd[24:16] < d1[24:16]), 1);
        d1 = rd;
        target <= 10'd450;
        cyc(5000);
        apb(0, ADDR_STATUS, 0);
        chk("duty_up", 32'(rd[24:16] > d1[24:16]), 1);
        unscrew <= 1'b0;
        lowb <= 1'b0;
        cyc(6);
        unscrew <= 1'b1;
        watch(1, 1000);
        chk("low_batt_drive", hi, 0);
        unscrew <= 1'b0;
        lowb <= 1'b1;
        cyc(6);
        $display("chop, duty and supply done");
    endtask
    task automatic t_tighten();
        screw <= 1'b1;
        cyc(600);
        watch(0, 500);
        chk("screw_rises", ro, 1);
        chk("screw_lamp", mlamp, 1);
        screw <= 1'b0;
        watch(2, 5 * TP + 40);
        chk("tighten_pulses", ro, TIGHTEN_PULSES);
        apb(0, ADDR_STATUS, 0);
        chk("state_off", rd[2:0], 3'h2);
        unscrew <= 1'b1;
        cyc(4);
        unscrew <= 1'b0;
        cyc(6);
        $display("tightening done");
    endtask
    task automatic t_charge();
        lowb <= 1'b0;
        usb <= 1'b1;
        cyc(10);
        chk("pre_up", refup, 0);
        chk("pre_lamp", clamp, 1);
        watch(4, 2560);
        chk("pre_ref", hi, 10 * REF_PRE_RESET);
        lowb <= 1'b1;
        cyc(10);
        chk("cc_up", refup, 1);
        watch(4, 2560);
        chk("cc_ref", hi, 290);
        apb(1, ADDR_REF_LO, 32'h04040440);
        cyc(300);
        watch(4, 2560);
        chk("cc_ref_new", hi, 640);
        apb(0, ADDR_STATUS, 0);
        chk("state_cc", rd[6:4], 3'h3);
        fullv <= 1'b1;
        cyc(10);
        chk("cv_up", refup, 0);
        chk("cv_sleep", sleep, 0);
        chgc <= 1'b0;
        cyc(10);
        chk("done_sleep", sleep, 1);
        watch(3, 200);
        chk("done_blink", ro, 10);
        usb <= 1'b0;
        cyc(6);
        chk("usb_gone", sleep, 0);
        $display("charging done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_motor();
        t_chop();
        t_tighten();
        t_charge();
        report_and_stop();
    end
endmodule
bind sdc_ctrl sdc_chk u_chk (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_UNSCREW_BUTTON(I_UNSCREW_BUTTON),
    .I_MOTOR_CURRENT_COMPARATOR(I_MOTOR_CURRENT_COMPARATOR), .I_LOW_BATTERY_COMPARATOR(I_LOW_BATTERY_COMPARATOR),
    .I_USB_PRESENT(I_USB_PRESENT), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .O_MOTOR_PWM_SCREW(O_MOTOR_PWM_SCREW), .O_MOTOR_PWM_UNSCREW(O_MOTOR_PWM_UNSCREW), .O_POWER_DOWN(O_POWER_DOWN),
    .O_MOTOR_ON_LAMP(O_MOTOR_ON_LAMP), .O_CHARGE_LAMP(O_CHARGE_LAMP), .O_CHARGE_REF_UP(O_CHARGE_REF_UP),
    .O_CHARGE_DONE_SLEEP(O_CHARGE_DONE_SLEEP));
`default_nettype wire
